// [palette_port_regs.svh]
`ifndef PALETTE_PORT_REGS_SVH
`define PALETTE_PORT_REGS_SVH

// Select line codes on register_select_lines
`define SEL_PTR_PAL_WR   3'h0
`define SEL_PAL_DATA     3'h1
`define SEL_READ_MASK    3'h2
`define SEL_PTR_PAL_RD   3'h3
`define SEL_PTR_OVL_WR   3'h4
`define SEL_OVL_DATA     3'h5
`define SEL_RESERVED     3'h6
`define SEL_PTR_OVL_RD   3'h7

// Reset values
`define POINTER_RESET    8'h00
`define MASK_RESET       8'hFF
`define PHASE_RESET      2'h0

// Color phase codes
`define PHASE_RED        2'h0
`define PHASE_GREEN      2'h1
`define PHASE_BLUE       2'h2

// Field positions
`define COLOR6_MSB       5
`define OVL_IDX_MSB      3

// Storage sizes
`define PAL_DEPTH        256
`define OVL_DEPTH        16

`endif

// [palette_port_pkg.sv]
package palette_port_pkg;

    // Host strobe sequencer states, Gray coded along idle-low-high
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_LOW    = 2'b01,
        ST_FINISH = 2'b11
    } strobe_state_t;

    // Kind of access latched from the select lines
    typedef enum logic [1:0] {
        ACC_NONE  = 2'b00,
        ACC_WRITE = 2'b01,
        ACC_READ  = 2'b10
    } access_kind_t;

    typedef logic [23:0] color_word_t;

endpackage : palette_port_pkg

// [color_store.sv]
`timescale 1ns/100ps
`include "palette_port_regs.svh"

// Palette and overlay storage with a one-cycle registered read port.
module color_store
(
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic                         wr_en,
    input  wire logic                         ovl_sel,
    input  wire logic [7:0]                   index,
    input  wire palette_port_pkg::color_word_t wr_word,
    output palette_port_pkg::color_word_t     rd_word
);

    palette_port_pkg::color_word_t pal_mem [`PAL_DEPTH]; // Palette entries
    palette_port_pkg::color_word_t ovl_mem [`OVL_DEPTH]; // Overlay entries
    logic [3:0]                    ovl_idx;              // Low nibble only

    // Upper nibble ignored for overlay access
    assign ovl_idx = index[`OVL_IDX_MSB:0];

    // Storage writes; overlay slot zero is reserved and never written
    always_ff @(posedge sys_clk)
    begin
        if (wr_en && !ovl_sel)
        begin
            pal_mem[index] <= wr_word;
        end
        if (wr_en && ovl_sel && ovl_idx != 4'h0)
        begin
            ovl_mem[ovl_idx] <= wr_word;
        end
    end

    // Registered read; reserved slot reads as zero (harmless)
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_word <= 24'h000000;
        end
        else if (ovl_sel)
        begin
            rd_word <= (ovl_idx == 4'h0) ? 24'h000000 : ovl_mem[ovl_idx];
        end
        else
        begin
            rd_word <= pal_mem[index];
        end
    end

endmodule : color_store

// [palette_host_access_port.sv]
`timescale 1ns/100ps
`include "palette_port_regs.svh"

// Functional notes
// - 8-bit pointer addresses palette and overlay
// - Low select codes: pointer modes, data, mask
// - High select codes: overlay pointer, data
// - Blue write stores joined three-byte word
// - Pointer advances after each blue write
// - Pointer load then RGB reads, then advance
// - Palette pointer wraps FFH to 00H
// - Overlay uses low nibble; zero reserved
// - Storage transfers placed between host accesses
// - Two-bit phase counts red, green, blue
// - Phase clears on pointer write and after blue
// - Pointer read changes nothing
// - Width select: high 8 bits, low 6
// - 8-bit mode: D0 LSB, D7 MSB
// - 6-bit mode: colour data D6, D7 ignored, read zero
// - Select at write fall, data at rise
// - Read strobe low drives data out
module palette_host_access_port
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_n,
    input  wire logic       rd_n,
    input  wire logic [2:0] register_select_lines,
    input  wire logic [7:0] host_byte_lines_in,
    input  wire logic       width_8bit_sel,
    output logic      [7:0] host_byte_lines_out,
    output logic      [7:0] host_byte_lines_oe_n,
    output logic      [7:0] read_mask,
    output logic      [7:0] location_pointer
);

    palette_port_pkg::strobe_state_t wr_st_q;   // Write strobe tracker
    palette_port_pkg::strobe_state_t rd_st_q;   // Read strobe tracker
    logic [2:0]                      wr_sel_q;  // Select latched at write fall
    logic [2:0]                      rd_sel_q;  // Select latched at read fall
    logic                            wr_done;   // Write strobe rising edge
    logic                            rd_fall;   // Read strobe falling edge
    logic                            rd_done;   // Read strobe rising edge
    logic [1:0]                      color_phase_count_q; // Hidden phase
    logic                            ovl_mode_q; // Pointer in overlay mode
    logic [7:0]                      red_q;     // Held red byte
    logic [7:0]                      green_q;   // Held green byte
    logic                            store_wr_q; // One-cycle store strobe
    logic                            store_ovl_q; // Target of that store
    palette_port_pkg::color_word_t   store_word_q; // Word being stored
    logic [7:0]                      store_idx_q; // Entry the store lands in
    palette_port_pkg::color_word_t   rd_word;   // Fetched color word
    logic [7:0]                      wr_byte;   // Write byte after width
    logic                            is_data_w; // Write to a data port
    logic                            is_data_r; // Read from a data port
    logic [7:0]                      out_d;     // Next read byte

    // Data ports are the palette and overlay codes only
    function automatic logic is_data_sel(input logic [2:0] s);
        is_data_sel = (s == `SEL_PAL_DATA) || (s == `SEL_OVL_DATA);
    endfunction : is_data_sel

    // Narrow a color byte per the width select
    function automatic logic [7:0] fit_width(input logic [7:0] b,
                                             input logic w8);
        fit_width = w8 ? b : {2'b00, b[`COLOR6_MSB:0]};
    endfunction : fit_width

    // Write strobe tracker: select on fall, data on rise
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_st_q  <= palette_port_pkg::ST_IDLE;
            wr_sel_q <= 3'h0;
        end
        else
        begin
            unique case (wr_st_q)
                palette_port_pkg::ST_IDLE:
                begin
                    if (!wr_n)
                    begin
                        wr_sel_q <= register_select_lines;
                        wr_st_q  <= palette_port_pkg::ST_LOW;
                    end
                end
                palette_port_pkg::ST_LOW:
                begin
                    if (wr_n)
                    begin
                        wr_st_q <= palette_port_pkg::ST_FINISH;
                    end
                end
                palette_port_pkg::ST_FINISH:
                begin
                    wr_st_q <= palette_port_pkg::ST_IDLE;
                end
                default:
                begin
                    wr_st_q <= palette_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Read strobe tracker: select on fall
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_st_q  <= palette_port_pkg::ST_IDLE;
            rd_sel_q <= 3'h0;
        end
        else
        begin
            unique case (rd_st_q)
                palette_port_pkg::ST_IDLE:
                begin
                    if (rd_fall)
                    begin
                        rd_sel_q <= register_select_lines;
                        rd_st_q  <= palette_port_pkg::ST_LOW;
                    end
                end
                palette_port_pkg::ST_LOW:
                begin
                    if (rd_n)
                    begin
                        rd_st_q <= palette_port_pkg::ST_FINISH;
                    end
                end
                palette_port_pkg::ST_FINISH:
                begin
                    rd_st_q <= palette_port_pkg::ST_IDLE;
                end
                default:
                begin
                    rd_st_q <= palette_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Data byte taken on the rising edge of the write strobe
    assign wr_done   = (wr_st_q == palette_port_pkg::ST_LOW) && wr_n;
    assign rd_fall   = (rd_st_q == palette_port_pkg::ST_IDLE) && !rd_n;
    assign rd_done   = (rd_st_q == palette_port_pkg::ST_LOW) && rd_n;
    assign wr_byte   = fit_width(host_byte_lines_in, width_8bit_sel);
    assign is_data_w = is_data_sel(wr_sel_q);
    assign is_data_r = is_data_sel(rd_sel_q);

    // Pointer, mode and phase; the pointer advances after blue
    // A pointer read never enters here, so mode and phase hold
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            location_pointer    <= `POINTER_RESET;
            color_phase_count_q <= `PHASE_RESET;
            ovl_mode_q          <= 1'b0;
        end
        else if (wr_done && !is_data_w && wr_sel_q[1] == wr_sel_q[0])
        begin
            // Pointer write in any of the four mode codes
            location_pointer    <= host_byte_lines_in;
            ovl_mode_q          <= wr_sel_q[2];
            color_phase_count_q <= `PHASE_RED;
        end
        else if ((wr_done && is_data_w) || (rd_done && is_data_r))
        begin
            if (color_phase_count_q == `PHASE_BLUE)
            begin
                // Eight-bit add wraps FFH to 00H on its own
                location_pointer    <= location_pointer + 8'h01;
                color_phase_count_q <= `PHASE_RED;
            end
            else
            begin
                color_phase_count_q <= color_phase_count_q + 2'h1;
            end
        end
    end

    // Pixel read mask register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            read_mask <= `MASK_RESET;
        end
        else if (wr_done && wr_sel_q == `SEL_READ_MASK)
        begin
            read_mask <= host_byte_lines_in;
        end
    end

    // Hold red and green; on blue, queue one store cycle after the strobe
    // Red and green wait for blue so a half-written entry never shows
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            red_q        <= 8'h00;
            green_q      <= 8'h00;
            store_wr_q   <= 1'b0;
            store_ovl_q  <= 1'b0;
            store_word_q <= 24'h000000;
        end
        else
        begin
            store_wr_q <= 1'b0;
            if (wr_done && is_data_w)
            begin
                unique case (color_phase_count_q)
                    `PHASE_RED:   red_q   <= wr_byte;
                    `PHASE_GREEN: green_q <= wr_byte;
                    `PHASE_BLUE:
                    begin
                        // Transfer runs while the host strobe is idle
                        store_wr_q   <= 1'b1;
                        store_ovl_q  <= wr_sel_q[2];
                        store_word_q <= {red_q, green_q, wr_byte};
                    end
                    default:      red_q   <= red_q;
                endcase
            end
        end
    end

    // Store index is the pointer before its blue-cycle advance
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            store_idx_q <= `POINTER_RESET;
        end
        else if (wr_done && is_data_w
                 && color_phase_count_q == `PHASE_BLUE)
        begin
            store_idx_q <= location_pointer;
        end
    end

    // Storage; index follows the pointer so reads prefetch ahead.
    // The store cycle borrows the index for one clock, so a read
    // that starts within two clocks of a blue write or a pointer
    // load may see the old word: the host must keep its idle gap.
    color_store u_store
    (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (store_wr_q),
        .ovl_sel (store_wr_q ? store_ovl_q : ovl_mode_q),
        .index   (store_wr_q ? store_idx_q : location_pointer),
        .wr_word (store_word_q),
        .rd_word (rd_word)
    );

    // Read byte chosen at the read strobe fall
    always_comb
    begin
        out_d = 8'h00; // Reserved code reads as zero
        unique case (rd_sel_q)
            `SEL_PTR_PAL_WR, `SEL_PTR_PAL_RD,
            `SEL_PTR_OVL_WR, `SEL_PTR_OVL_RD:
                out_d = location_pointer;
            `SEL_READ_MASK:
                out_d = read_mask;
            `SEL_PAL_DATA, `SEL_OVL_DATA:
            begin
                unique case (color_phase_count_q)
                    `PHASE_RED:   out_d = rd_word[23:16];
                    `PHASE_GREEN: out_d = rd_word[15:8];
                    default:      out_d = rd_word[7:0];
                endcase
                out_d = fit_width(out_d, width_8bit_sel);
            end
            default:
                out_d = 8'h00;
        endcase
    end

    // Drive the bus while the read strobe is low
    // Enable and data both come from flops so the pins never glitch
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_byte_lines_out  <= 8'h00;
            host_byte_lines_oe_n <= 8'hFF;
        end
        else
        begin
            host_byte_lines_out  <= out_d;
            host_byte_lines_oe_n <= (rd_st_q == palette_port_pkg::ST_LOW
                                     && !rd_n) ? 8'h00 : 8'hFF;
        end
    end

endmodule : palette_host_access_port

// [palette_host_access_port_properties.sv]
`timescale 1ns/100ps
`include "palette_port_regs.svh"

// Pin-level checks on the host port, sampled on the system clock
module palette_port_checker
(
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic [2:0] register_select_lines,
    input wire logic [7:0] host_byte_lines_in,
    input wire logic       width_8bit_sel,
    input wire logic [7:0] host_byte_lines_out,
    input wire logic [7:0] host_byte_lines_oe_n,
    input wire logic [7:0] read_mask,
    input wire logic [7:0] location_pointer
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire logic [2:0] sel = register_select_lines; // Short alias
    wire logic [7:0] oe  = host_byte_lines_oe_n;  // Short alias
    wire logic [7:0] dat = host_byte_lines_in;    // Short alias

    property p_oe_off; rd_n [*3] |-> oe == 8'hFF; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("bus driven without read strobe");
    property p_oe_on; $fell(rd_n) |-> ##[1:3] oe == 8'h00; endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("read data not driven");
    // Read data is sampled one edge after launch, when rd_n is high
    property p_six; !width_8bit_sel && oe == 8'h00
        && (sel == `SEL_PAL_DATA || sel == `SEL_OVL_DATA)
        |-> host_byte_lines_out[7:6] == 2'h0; endproperty
    a_six: assert property (p_six)
        else $error("upper colour bits not zero");
    property p_ptr_load; $rose(wr_n) && sel == `SEL_PTR_PAL_WR
        |=> location_pointer == $past(dat); endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer not loaded");
    property p_ovl_load; $rose(wr_n) && sel == `SEL_PTR_OVL_WR
        |=> location_pointer == $past(dat); endproperty
    a_ovl_load: assert property (p_ovl_load)
        else $error("overlay pointer not loaded");
    property p_mask_load; $rose(wr_n) && sel == `SEL_READ_MASK
        |=> read_mask == $past(dat); endproperty
    a_mask_load: assert property (p_mask_load)
        else $error("mask not loaded");
    // The mask may only move one edge after a write strobe rises
    property p_mask_hold; $changed(read_mask)
        |-> $past(wr_n) && !$past(wr_n, 2); endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask changed outside a write");
    property p_ptr_rd; !rd_n && sel == `SEL_PTR_PAL_RD
        |=> $stable(location_pointer); endproperty
    a_ptr_rd: assert property (p_ptr_rd)
        else $error("pointer read moved pointer");
    property p_rsvd; sel == `SEL_RESERVED && oe == 8'h00
        |-> host_byte_lines_out == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved read not zero");

    c_wr_data: cover property ($rose(wr_n) && sel == `SEL_PAL_DATA);
    c_rd_ovl: cover property ($fell(rd_n) && sel == `SEL_OVL_DATA);
    c_six: cover property (!width_8bit_sel && oe == 8'h00);
endmodule : palette_port_checker

bind palette_host_access_port palette_port_checker i_chk
(
    .sys_clk(sys_clk), .rst_n(rst_n), .wr_n(wr_n), .rd_n(rd_n),
    .register_select_lines(register_select_lines),
    .host_byte_lines_in(host_byte_lines_in),
    .width_8bit_sel(width_8bit_sel),
    .host_byte_lines_out(host_byte_lines_out),
    .host_byte_lines_oe_n(host_byte_lines_oe_n),
    .read_mask(read_mask), .location_pointer(location_pointer)
);

// [host_bus_model.sv]
`timescale 1ns/100ps

// Host processor bus; every change lands on a falling clock edge
module host_bus_model
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] host_byte_lines_out,
    input  wire logic [7:0] host_byte_lines_oe_n,
    output logic            wr_n,
    output logic            rd_n,
    output logic      [2:0] register_select_lines,
    output logic      [7:0] host_byte_lines_in
);
    // Idle bus at time zero
    initial
    begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        register_select_lines = 3'h0;
        host_byte_lines_in = 8'h00;
    end

    // Select goes with the falling strobe, data goes with the rise and is held three clocks after it
    task wr(input logic [2:0] s, input logic [7:0] d);
        @(negedge sys_clk);
        wr_n = 1'b0;
        register_select_lines = s;
        host_byte_lines_in = ~d;
        repeat (2) @(negedge sys_clk);
        host_byte_lines_in = d;
        wr_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        host_byte_lines_in = ~d; // Released bus shows no stale value
    endtask : wr

    // Strobe stays low until the port drives, then data is taken
    task rd(input logic [2:0] s, output logic [7:0] d);
        int n;
        @(negedge sys_clk);
        rd_n = 1'b0;
        register_select_lines = s;
        n = 0;
        while (host_byte_lines_oe_n !== 8'h00 && n < 8)
        begin
            @(negedge sys_clk);
            n++;
        end
        d = host_byte_lines_out;
        rd_n = 1'b1;
        repeat (3) @(negedge sys_clk); // Gives the prefetch time
    endtask : rd
endmodule : host_bus_model

// [test_palette_host_access_port.sv]
`timescale 1ns/100ps

module test_palette_host_access_port;
    logic       sys_clk = 1'b0;        // 50 MHz clock
    logic       rst_n = 1'b0;          // Held low at start
    logic       width_8bit_sel = 1'b1; // Colour width
    logic       wr_n, rd_n;            // Host strobes
    logic [2:0] sel;                   // Select lines
    logic [7:0] din, dout, oe_n;       // Data bus halves
    logic [7:0] mask, ptr, v;          // Observed values
    int         mismatches = 0;
    int         checks = 0;
    int         cycles = 0;

    always #10 sys_clk = ~sys_clk;

    palette_host_access_port i_dut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .wr_n(wr_n), .rd_n(rd_n),
        .register_select_lines(sel), .host_byte_lines_in(din),
        .width_8bit_sel(width_8bit_sel), .host_byte_lines_out(dout),
        .host_byte_lines_oe_n(oe_n), .read_mask(mask),
        .location_pointer(ptr)
    );
    host_bus_model i_host
    (
        .sys_clk(sys_clk), .host_byte_lines_out(dout),
        .host_byte_lines_oe_n(oe_n), .wr_n(wr_n), .rd_n(rd_n),
        .register_select_lines(sel), .host_byte_lines_in(din)
    );

    task chk(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // Red, green, blue in that order, as the phase counter expects
    task wr3(input logic [2:0] s, input logic [7:0] r, g, b);
        i_host.wr(s, r);
        i_host.wr(s, g);
        i_host.wr(s, b);
    endtask : wr3

    task rd3(input logic [2:0] s, input logic [7:0] r, g, b);
        i_host.rd(s, v);
        chk("red", r, v);
        i_host.rd(s, v);
        chk("green", g, v);
        i_host.rd(s, v);
        chk("blue", b, v);
    endtask : rd3

    task t_reset;
        chk("pointer", 8'h00, ptr);
        chk("mask", 8'hFF, mask);
        chk("enable", 8'hFF, oe_n);
    endtask : t_reset

    // Mask write and read back; reserved code must touch nothing
    task t_mask;
        i_host.wr(3'h2, 8'h5A);
        chk("mask", 8'h5A, mask);
        i_host.rd(3'h2, v);
        chk("mask read", 8'h5A, v);
        i_host.wr(3'h6, 8'h11);
        chk("mask", 8'h5A, mask);
        i_host.rd(3'h6, v);
        chk("reserved", 8'h00, v);
    endtask : t_mask

    // Wrap at the top entry, pointer read in mid-triple
    task t_palette;
        i_host.wr(3'h0, 8'hFF);
        wr3(3'h1, 8'h11, 8'h22, 8'h33);
        chk("pointer", 8'h00, ptr);
        i_host.wr(3'h3, 8'hFF);
        i_host.rd(3'h1, v);
        chk("red", 8'h11, v);
        i_host.rd(3'h3, v);
        chk("pointer read", 8'hFF, v);
        i_host.rd(3'h1, v);
        chk("green", 8'h22, v);
        i_host.rd(3'h1, v);
        chk("blue", 8'h33, v);
        chk("pointer", 8'h00, ptr);
    endtask : t_palette

    // A pointer write mid-triple restarts at red
    task t_phase;
        i_host.wr(3'h0, 8'h20);
        i_host.wr(3'h1, 8'hAA);
        i_host.wr(3'h0, 8'h20);
        wr3(3'h1, 8'h01, 8'h02, 8'h03);
        i_host.wr(3'h3, 8'h20);
        rd3(3'h1, 8'h01, 8'h02, 8'h03);
    endtask : t_phase

    task t_six;
        width_8bit_sel = 1'b0;
        i_host.wr(3'h0, 8'h10);
        wr3(3'h1, 8'hFF, 8'hC1, 8'h80);
        i_host.wr(3'h3, 8'h10);
        rd3(3'h1, 8'h3F, 8'h01, 8'h00);
        width_8bit_sel = 1'b1;
        // Full bytes stored wide, read back narrow: upper bits zero
        i_host.wr(3'h0, 8'h11);
        wr3(3'h1, 8'hC0, 8'hFF, 8'h41);
        width_8bit_sel = 1'b0;
        i_host.wr(3'h3, 8'h11);
        rd3(3'h1, 8'h00, 8'h3F, 8'h01);
        width_8bit_sel = 1'b1;
    endtask : t_six

    // Upper nibble ignored; slot zero holds nothing
    task t_overlay;
        i_host.wr(3'h4, 8'h23);
        wr3(3'h5, 8'hA1, 8'hB2, 8'hC3);
        chk("pointer", 8'h24, ptr);
        i_host.wr(3'h7, 8'h13);
        rd3(3'h5, 8'hA1, 8'hB2, 8'hC3);
        i_host.wr(3'h4, 8'h40);
        wr3(3'h5, 8'h77, 8'h88, 8'h99);
        i_host.wr(3'h7, 8'h40);
        rd3(3'h5, 8'h00, 8'h00, 8'h00);
    endtask : t_overlay

    // Cuts a hang short; the whole run needs under 2000 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            wrap_up();
        end
    end

    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        t_reset();
        t_mask();
        t_palette();
        t_phase();
        t_six();
        t_overlay();
        wrap_up();
    end
endmodule : test_palette_host_access_port
